// file: src/asu_idle_counter.sv
// Four-bit idle counter run on the dedicated idle clock edge
`timescale 1ns/1ps
`include "asu_map.svh"
module asu_idle_counter (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic enable_i,
  input wire logic strobe_seen_i,
  input wire logic idle_edge_i,
  // Status
  output logic [3:0] count_o,
  output logic limit_o
);
  logic [3:0] count;
  logic [3:0] next_count;

  // Clear on strobe activity, count idle clock edges, hold at the limit
  always_comb begin
    next_count = count;
    if (!enable_i || strobe_seen_i) begin
      next_count = 4'h0;
    end else if (idle_edge_i && count != `ASU_IDLE_LIMIT) begin
      next_count = count + 4'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= 4'h0;
    end else begin
      count <= next_count;
    end
  end

  assign count_o = count;
  assign limit_o = (count == `ASU_IDLE_LIMIT);

  // Count never passes the limit
  a_count_saturates: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (count == `ASU_IDLE_LIMIT && enable_i && !strobe_seen_i) |=> count == `ASU_IDLE_LIMIT)
    else $error("idle count left saturation");
endmodule : asu_idle_counter

// file: src/asu_map.svh
// Constants for the auto sleep unit: bit positions, reset values and counts
`ifndef ASU_MAP_SVH
`define ASU_MAP_SVH
// ---------------------------------------------------------------------------
// Power mode register zero fields
// ---------------------------------------------------------------------------
`define ASU_PMR0_SLEEP_EN_BIT 1
`define ASU_PMR0_TURBO_OFF_BIT 3
`define ASU_PMR0_ARRAY_CLK_OFF_BIT 4
`define ASU_PMR0_MCELL_CLK_OFF_BIT 5
// ---------------------------------------------------------------------------
// Power mode register two fields
// ---------------------------------------------------------------------------
`define ASU_PMR2_CTRL0_OFF_BIT 2
`define ASU_PMR2_CTRL1_OFF_BIT 3
`define ASU_PMR2_CTRL2_OFF_BIT 4
`define ASU_PMR2_STROBE_OFF_BIT 5
`define ASU_PMR2_DBE_OFF_BIT 6
// ---------------------------------------------------------------------------
// Reset values and counts
// ---------------------------------------------------------------------------
`define ASU_PMR_RESET 8'h00
`define ASU_IDLE_LIMIT 4'hF
`define ASU_NUM_SELECTS 3
`endif

// file: src/asu_pkg.sv
// Types shared by the auto sleep unit files
package asu_pkg;
  // Sleep state of the unit
  typedef enum logic [0:0] {
    ASU_AWAKE = 1'b0,
    ASU_ASLEEP = 1'b1
  } asu_state_type;
endpackage : asu_pkg

// file: src/asu_top.sv
// Auto sleep unit: idle watch, sleep gating, input blocking and external selects
// ---------------------------------------------------------------------------
// Contract
// - When enabled and strobe stops, four-bit idle counter runs on the idle clock.
// - Fifteen idle clock periods without strobe raise sleep request.
// - Enabling the unit enables sleep entry with no other setting.
// - Strobe pulsing again wakes the device.
// - Chip select low or reset returning high also wakes the device.
// - Asleep blocks bus address/data to memories and arrays; memories deselected.
// - Asleep puts memories in standby; logic and ports keep running.
// - Asleep: I/O and logic pins hold, address pins undefined, data pins tri-state.
// - Sleep does not alter logic; speed depends only on turbo setting.
// - Blocking idle clock from arrays still feeds the idle counter.
// - Power registers writable at run time; set blocking bit blocks its signal.
// - Register zero bit 3 one disables turbo; zero is full speed.
// - Port D pin 0 strobe, pin 1 idle clock, pin 2 active-low select.
// - Select low enables flash, EEPROM, SRAM and I/O space.
// - Select high disables memories; logic and pins stay working, nothing blocked.
// - Three external selects, each one product term with settable polarity.
// - Select pin enable from its enable term or its direction bit.
// - Memories idle in standby while inputs steady, wake on transitions; here standby follows the memory select, not input activity.
// - Register zero bit 1 enables auto sleep.
// - Register zero bit 4 cuts clock to array, bit 5 to macrocells.
// - Register two bits 2..6 cut control inputs, strobe, byte enable from array.
// - Power registers clear at power-up only, not on later resets.
// ---------------------------------------------------------------------------
`timescale 1ns/1ps
`include "asu_map.svh"
module asu_top (
  // Clock and resets
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic power_up_b_i,
  // Port D pins
  input wire logic port_d_pin_zero_i,
  input wire logic port_d_pin_one_i,
  input wire logic port_d_pin_two_i,
  // Other control inputs
  input wire logic control_input_zero_i,
  input wire logic control_input_one_i,
  input wire logic control_input_two_i,
  input wire logic data_byte_enable_in_i,
  // Power register writes
  input wire logic pmr0_we_i,
  input wire logic pmr2_we_i,
  input wire logic [7:0] pmr_wdata_i,
  // Bus and memory requests from the host side
  input wire logic [15:0] bus_addr_i,
  input wire logic [7:0] bus_data_i,
  input wire logic mem_req_i,
  // External select product terms
  input wire logic [2:0] select_term_i,
  input wire logic [2:0] select_active_high_i,
  input wire logic [2:0] select_oe_term_i,
  input wire logic [2:0] select_oe_term_used_i,
  input wire logic [2:0] select_dir_i,
  // Pin enable requests of the port logic
  input wire logic addr_pin_oe_req_i,
  input wire logic data_pin_oe_req_i,
  // Register read back
  output logic [7:0] power_mode_reg_zero_o,
  output logic [7:0] power_mode_reg_two_o,
  // Sleep status
  output logic sleep_request_o,
  output logic [3:0] idle_count_o,
  // Gated paths to memories and arrays
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_data_o,
  output logic mem_select_o,
  output logic mem_standby_o,
  output logic turbo_on_o,
  // Gated array inputs
  output logic array_clk_o,
  output logic mcell_clk_o,
  output logic [2:0] array_ctrl_o,
  output logic array_strobe_o,
  output logic array_dbe_o,
  // Pin enables, low while driving
  output logic addr_pin_oe_b_o,
  output logic data_pin_oe_b_o,
  // External select pins
  output logic [`ASU_NUM_SELECTS-1:0] external_select_out_o,
  output logic [`ASU_NUM_SELECTS-1:0] external_select_oe_b_o
);
  // -------------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------------
  logic [7:0] pmr0;
  logic [7:0] next_pmr0;
  logic [7:0] pmr2;
  logic [7:0] next_pmr2;
  asu_pkg::asu_state_type state;
  asu_pkg::asu_state_type next_state;
  logic strobe_q;
  logic clk_q;
  logic sel_q;
  logic rst_seen;
  logic strobe_seen;
  logic idle_edge;
  logic select_fall;
  logic restart;
  logic sleep_en;
  logic [3:0] count;
  logic at_limit;
  logic asleep_next;
  logic [15:0] next_addr;
  logic [7:0] next_data;
  logic next_msel;
  logic [2:0] next_ctrl;
  logic next_aclk;
  logic next_mclk;
  logic next_astb;
  logic next_adbe;
  logic [2:0] next_ecs;
  logic [2:0] next_ecs_oe_b;

  // -------------------------------------------------------------------------
  // Power mode registers
  // -------------------------------------------------------------------------
  // Cleared by the power-up reset only, so warm resets keep the settings
  always_comb begin
    next_pmr0 = pmr0;
    next_pmr2 = pmr2;
    if (pmr0_we_i) begin
      next_pmr0 = pmr_wdata_i;
    end
    if (pmr2_we_i) begin
      next_pmr2 = pmr_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge power_up_b_i) begin
    if (!power_up_b_i) begin
      pmr0 <= `ASU_PMR_RESET;
      pmr2 <= `ASU_PMR_RESET;
    end else begin
      pmr0 <= next_pmr0;
      pmr2 <= next_pmr2;
    end
  end

  // -------------------------------------------------------------------------
  // Pin edge detection
  // -------------------------------------------------------------------------
  // Pins are synchronous; one stage of history gives the edges
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strobe_q <= 1'b0;
      clk_q <= 1'b0;
      sel_q <= 1'b1;
      rst_seen <= 1'b1;
    end else begin
      strobe_q <= port_d_pin_zero_i;
      clk_q <= port_d_pin_one_i;
      sel_q <= port_d_pin_two_i;
      rst_seen <= 1'b0;
    end
  end

  assign strobe_seen = port_d_pin_zero_i && !strobe_q;
  // Counter sees every idle clock edge, whatever the array blocking bits say
  assign idle_edge = port_d_pin_one_i && !clk_q;
  assign select_fall = !port_d_pin_two_i && sel_q;
  // Every wake term restarts the count; a saturated count left standing
  // would drop the unit straight back to sleep one cycle after waking
  assign restart = strobe_seen || select_fall || rst_seen;
  // One bit enables both the counter and sleep entry
  assign sleep_en = pmr0[`ASU_PMR0_SLEEP_EN_BIT];

  asu_idle_counter u_idle (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .enable_i(sleep_en),
    .strobe_seen_i(restart),
    .idle_edge_i(idle_edge),
    .count_o(count),
    .limit_o(at_limit)
  );

  // -------------------------------------------------------------------------
  // Sleep state
  // -------------------------------------------------------------------------
  // The strobe wake term takes priority over entry so a strobe is never lost; a select fall at the limit does not block entry
  always_comb begin
    next_state = state;
    case (state)
      asu_pkg::ASU_AWAKE: begin
        if (sleep_en && at_limit && !strobe_seen) begin
          next_state = asu_pkg::ASU_ASLEEP;
        end
      end
      asu_pkg::ASU_ASLEEP: begin
        if (strobe_seen || select_fall || rst_seen || !sleep_en) begin
          next_state = asu_pkg::ASU_AWAKE;
        end
      end
      default: begin
        next_state = asu_pkg::ASU_AWAKE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= asu_pkg::ASU_AWAKE;
    end else begin
      state <= next_state;
    end
  end

  assign asleep_next = (next_state == asu_pkg::ASU_ASLEEP);

  // -------------------------------------------------------------------------
  // Gated bus, memory and array inputs
  // -------------------------------------------------------------------------
  // Sleep blocks bus lines; logic paths ignore sleep and follow blocking bits
  always_comb begin
    next_addr = asleep_next ? mem_addr_o : bus_addr_i;
    next_data = asleep_next ? mem_data_o : bus_data_i;
    next_msel = mem_req_i && !port_d_pin_two_i && !asleep_next;
    next_aclk = port_d_pin_one_i && !pmr0[`ASU_PMR0_ARRAY_CLK_OFF_BIT];
    next_mclk = port_d_pin_one_i && !pmr0[`ASU_PMR0_MCELL_CLK_OFF_BIT];
    next_ctrl[0] = control_input_zero_i && !pmr2[`ASU_PMR2_CTRL0_OFF_BIT];
    next_ctrl[1] = control_input_one_i && !pmr2[`ASU_PMR2_CTRL1_OFF_BIT];
    next_ctrl[2] = control_input_two_i && !pmr2[`ASU_PMR2_CTRL2_OFF_BIT];
    next_astb = port_d_pin_zero_i && !pmr2[`ASU_PMR2_STROBE_OFF_BIT];
    next_adbe = data_byte_enable_in_i && !pmr2[`ASU_PMR2_DBE_OFF_BIT];
  end

  // -------------------------------------------------------------------------
  // External selects
  // -------------------------------------------------------------------------
  // Pins driven from the product terms keep running through sleep
  always_comb begin
    for (int i = 0; i < `ASU_NUM_SELECTS; i++) begin
      next_ecs[i] = select_active_high_i[i] ? select_term_i[i] : !select_term_i[i];
      next_ecs_oe_b[i] = select_oe_term_used_i[i] ? !select_oe_term_i[i]
                                                  : !select_dir_i[i];
    end
  end

  // -------------------------------------------------------------------------
  // Output registers
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sleep_request_o <= 1'b0;
      idle_count_o <= 4'h0;
      mem_addr_o <= 16'h0000;
      mem_data_o <= 8'h00;
      mem_select_o <= 1'b0;
      mem_standby_o <= 1'b1;
      turbo_on_o <= 1'b1;
      array_clk_o <= 1'b0;
      mcell_clk_o <= 1'b0;
      array_ctrl_o <= 3'h0;
      array_strobe_o <= 1'b0;
      array_dbe_o <= 1'b0;
      addr_pin_oe_b_o <= 1'b1;
      data_pin_oe_b_o <= 1'b1;
      external_select_out_o <= 3'h0;
      external_select_oe_b_o <= 3'h7;
      power_mode_reg_zero_o <= 8'h00;
      power_mode_reg_two_o <= 8'h00;
    end else begin
      sleep_request_o <= asleep_next;
      idle_count_o <= count;
      mem_addr_o <= next_addr;
      mem_data_o <= next_data;
      mem_select_o <= next_msel;
      // Standby unless a select is active; static memories sleep on idle
      mem_standby_o <= !next_msel;
      turbo_on_o <= !pmr0[`ASU_PMR0_TURBO_OFF_BIT];
      array_clk_o <= next_aclk;
      mcell_clk_o <= next_mclk;
      array_ctrl_o <= next_ctrl;
      array_strobe_o <= next_astb;
      array_dbe_o <= next_adbe;
      // Address pins are released while asleep, so their level is undefined
      addr_pin_oe_b_o <= !addr_pin_oe_req_i || asleep_next;
      data_pin_oe_b_o <= !data_pin_oe_req_i || asleep_next;
      external_select_out_o <= next_ecs;
      external_select_oe_b_o <= next_ecs_oe_b;
      power_mode_reg_zero_o <= next_pmr0;
      power_mode_reg_two_o <= next_pmr2;
    end
  end

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  a_sleep_after_limit: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (state == asu_pkg::ASU_AWAKE && sleep_en && at_limit && !strobe_seen)
    |=> sleep_request_o) else $error("no sleep after idle limit");
  a_strobe_wakes: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (state == asu_pkg::ASU_ASLEEP && strobe_seen) |=> !sleep_request_o)
    else $error("strobe did not wake");
  a_select_wakes: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (state == asu_pkg::ASU_ASLEEP && select_fall) |=> !sleep_request_o [*2])
    else $error("select low did not wake");
  a_mem_deselect: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    sleep_request_o |-> !mem_select_o) else $error("memory selected asleep");
  a_addr_frozen: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (sleep_request_o && $past(sleep_request_o)) |-> $stable(mem_addr_o))
    else $error("address passed while asleep");
  a_select_high_off: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    port_d_pin_two_i |=> !mem_select_o) else $error("memory on with select high");
  a_no_sleep_disabled: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !sleep_en [*2] |-> ##1 !sleep_request_o) else $error("sleep while disabled");
  a_turbo_follows: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    $rose(pmr0[`ASU_PMR0_TURBO_OFF_BIT]) |=> !turbo_on_o) else $error("turbo stuck");
  a_strobe_blocked: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    pmr2[`ASU_PMR2_STROBE_OFF_BIT] |=> !array_strobe_o) else $error("strobe not blocked");
  a_data_tristate: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    sleep_request_o |-> data_pin_oe_b_o) else $error("data pins driven asleep");
endmodule : asu_top

// file: tb/asu_host_model.sv
// Host bus model: address strobe, idle count clock and bus lines
`timescale 1ns/1ps
module asu_host_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Bench control
  input wire logic active_i,
  // Bus side
  output logic strobe_o,
  output logic idle_clk_o,
  output logic [15:0] addr_o,
  output logic [7:0] data_o
);
  logic [2:0] div;
  // Strobe every 4 cycles, idle clock period 8: ratio stays far below fifteen
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div <= 3'h0;
      strobe_o <= 1'b0;
      idle_clk_o <= 1'b0;
      addr_o <= 16'h0000;
      data_o <= 8'h00;
    end else begin
      div <= div + 3'h1;
      idle_clk_o <= div[2];
      strobe_o <= active_i && (div[1:0] == 2'h0);
      // Released bus lines toggle so a stale value is never mistaken for a hold
      addr_o <= active_i ? addr_o + 16'h0001 : ~addr_o;
      data_o <= active_i ? addr_o[7:0] : ~data_o;
    end
  end
endmodule : asu_host_model

// file: tb/tb_asu_top.sv
// Self-checking bench for the auto sleep unit
`timescale 1ns/1ps
module tb_asu_top;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic pwr_b = 1'b0;
  logic act = 1'b0;
  logic cs_b = 1'b0;
  logic [2:0] ctl = 3'h7;
  logic dbe = 1'b1;
  logic we0 = 1'b0;
  logic we2 = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [2:0] term = 3'h0, ah = 3'h0, oet = 3'h0, oeu = 3'h0, dir = 3'h0;
  logic [15:0] h_addr;
  logic [7:0] h_data, r0, r2, m_data;
  logic strobe, iclk, sleep, sel, stby, turbo, aclk, mclk, astb, adbe, aoe_b, doe_b;
  logic [3:0] cnt;
  logic [15:0] m_addr, held;
  logic [2:0] actl, es, es_oe_b;
  int mismatches = 0;
  int compares = 0;
  int seen_hi;

  // ---------------------------------------------------------------------------
  // Clock, partner and design
  // ---------------------------------------------------------------------------
  initial forever #25 core_clk = ~core_clk;

  asu_host_model i_host (.core_clk_i(core_clk), .rst_b_i(rst_b), .active_i(act),
    .strobe_o(strobe), .idle_clk_o(iclk), .addr_o(h_addr), .data_o(h_data));

  asu_top i_dut (.core_clk_i(core_clk), .rst_b_i(rst_b), .power_up_b_i(pwr_b),
    .port_d_pin_zero_i(strobe), .port_d_pin_one_i(iclk), .port_d_pin_two_i(cs_b),
    .control_input_zero_i(ctl[0]), .control_input_one_i(ctl[1]),
    .control_input_two_i(ctl[2]), .data_byte_enable_in_i(dbe),
    .pmr0_we_i(we0), .pmr2_we_i(we2), .pmr_wdata_i(wd),
    .bus_addr_i(h_addr), .bus_data_i(h_data), .mem_req_i(1'b1),
    .select_term_i(term), .select_active_high_i(ah), .select_oe_term_i(oet),
    .select_oe_term_used_i(oeu), .select_dir_i(dir),
    .addr_pin_oe_req_i(1'b1), .data_pin_oe_req_i(1'b1),
    .power_mode_reg_zero_o(r0), .power_mode_reg_two_o(r2),
    .sleep_request_o(sleep), .idle_count_o(cnt), .mem_addr_o(m_addr),
    .mem_data_o(m_data), .mem_select_o(sel), .mem_standby_o(stby), .turbo_on_o(turbo),
    .array_clk_o(aclk), .mcell_clk_o(mclk), .array_ctrl_o(actl),
    .array_strobe_o(astb), .array_dbe_o(adbe),
    .addr_pin_oe_b_o(aoe_b), .data_pin_oe_b_o(doe_b),
    .external_select_out_o(es), .external_select_oe_b_o(es_oe_b));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  // One-cycle write strobe to register zero or two
  task automatic wr(input bit two, input logic [7:0] d);
    @(posedge core_clk);
    we0 <= !two;
    we2 <= two;
    wd <= d;
    @(posedge core_clk);
    we0 <= 1'b0;
    we2 <= 1'b0;
    cyc(1);
  endtask : wr

  // Bus goes quiet, then sleep must come with the counter at its limit
  task automatic go_sleep();
    int n;
    @(posedge core_clk);
    act <= 1'b0;
    n = 0;
    while (sleep !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    chk(sleep, 16'h1);
    chk(cnt, 16'hF);
  endtask : go_sleep

  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (6000) @(posedge core_clk);
    mismatches++;
    report_and_stop();
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    pwr_b <= 1'b1;
    rst_b <= 1'b1;
    cyc(2);
    chk({r0, r2}, 16'h0000);
    chk(turbo, 16'h1);
    // Disabled unit never sleeps on a quiet bus
    cyc(200);
    chk(sleep, 16'h0);
    chk(sel, 16'h1);
    chk(stby, 16'h0);
    wr(0, 8'h02);
    chk(r0, 16'h02);
    go_sleep();
    chk(sel, 16'h0);
    chk(stby, 16'h1);
    chk({aoe_b, doe_b}, 16'h3);
    held = m_addr;
    cyc(5);
    chk(m_addr, held);
    held = {8'h00, m_data};
    cyc(2);
    chk(m_data, held);
    chk(actl, 16'h7);
    // Strobe resumes
    @(posedge core_clk);
    act <= 1'b1;
    cyc(8);
    chk(sleep, 16'h0);
    chk(cnt, 16'h0);
    chk(sel, 16'h1);
    chk({aoe_b, doe_b}, 16'h0);
    // Chip select going low wakes
    go_sleep();
    @(posedge core_clk);
    cs_b <= 1'b1;
    cyc(3);
    @(posedge core_clk);
    cs_b <= 1'b0;
    cyc(2);
    chk(sleep, 16'h0);
    // Deselected: memories off, array inputs not blocked
    @(posedge core_clk);
    cs_b <= 1'b1;
    act <= 1'b1;
    cyc(3);
    chk(sel, 16'h0);
    chk({actl, adbe}, 16'hF);
    @(posedge core_clk);
    cs_b <= 1'b0;
    // Warm reset wakes and keeps the registers
    go_sleep();
    @(posedge core_clk);
    rst_b <= 1'b0;
    @(posedge core_clk);
    rst_b <= 1'b1;
    cyc(2);
    chk(sleep, 16'h0);
    chk(r0, 16'h02);
    // Turbo off, clock cut from both arrays: counter still runs to sleep
    wr(0, 8'h3A);
    chk(turbo, 16'h0);
    seen_hi = 0;
    go_sleep();
    chk(turbo, 16'h0);
    for (int k = 0; k < 20; k++) begin
      cyc(1);
      seen_hi += aclk + mclk;
    end
    chk(16'(seen_hi), 16'h0);
    wr(0, 8'h00);
    for (int k = 0; k < 20; k++) begin
      cyc(1);
      seen_hi += aclk & mclk;
    end
    chk(seen_hi != 0, 16'h1);
    // Each blocking bit of register two; strobe runs so its own bit shows
    @(posedge core_clk);
    act <= 1'b1;
    for (int b = 2; b < 7; b++) begin
      wr(1, 8'h01 << b);
      cyc(1);
      chk({actl, adbe}, 16'hF & ~(b == 6 ? 16'h1 : b == 5 ? 16'h0 : 16'h2 << (b - 2)));
      // Strobe pulses once every four cycles, so eight samples hold two
      seen_hi = 0;
      for (int k = 0; k < 8; k++) begin
        cyc(1);
        seen_hi += astb;
      end
      chk(16'(seen_hi), b == 5 ? 16'h0 : 16'h2);
    end
    // External selects: polarity and output enable source
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk);
      term <= i[2:0];
      ah <= i[3] ? 3'h5 : 3'h2;
      oet <= ~i[2:0];
      oeu <= 3'h3;
      dir <= i[3:1];
      cyc(2);
      chk(es, 3'(~(term ^ ah)));
      chk(es_oe_b, 3'(~((oeu & oet) | (~oeu & dir))));
    end
    // Power-up reset clears the registers
    @(posedge core_clk);
    pwr_b <= 1'b0;
    @(posedge core_clk);
    pwr_b <= 1'b1;
    cyc(2);
    chk({r0, r2}, 16'h0000);
    report_and_stop();
  end
endmodule : tb_asu_top
